// file: hdl/sus_top.sv
// Synchronous shift serial unit with AXI4-Lite registers
`timescale 1ns/1ps
`include "sus_consts.svh"
module sus_top import sus_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic cts_n,
   input wire logic baud_clock_in,
   output logic txd,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe_n,
   output logic chan1_rx_irq_out,
   output logic chan1_tx_irq_out
);
   logic cts_n_s, bclk_s, rxd_s;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic awready_d, wready_d, arready_d, bvalid_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   sus_ctrl_t ctrl_q, ctrl_d;
   logic [15:0] bcmp_q, bcmp_d;
   logic [7:0] tbuf_q, tbuf_d, rbuf_q, rbuf_d;
   logic tbuf_full_q, tbuf_full_d, ti_q, ti_d, ri_q, ri_d, rx_req_q, rx_req_d;
   logic tx_irq_d, rx_irq_d;
   logic wr_go, rd_go, rd_sts;
   sus_eng_t e_q, e_d;
   logic sync_mode, int_tb, cts_edge, bclk_rise, inc, match, ext_match, tick;
   logic tx_load, rx_start, tx_done, rx_done;
   logic [14:0] cmp;

   // Pins from outside pass two flops first
   sus_sync #(.RST_VAL(1'b1)) u_cts (.aclk(aclk), .aresetn(aresetn), .d(cts_n), .q(cts_n_s));
   sus_sync #(.RST_VAL(1'b0)) u_bclk (.aclk(aclk), .aresetn(aresetn), .d(baud_clock_in),
      .q(bclk_s));
   sus_sync #(.RST_VAL(1'b1)) u_rxd (.aclk(aclk), .aresetn(aresetn), .d(rxd_in), .q(rxd_s));

   assign sync_mode = (ctrl_q.mode == `SUS_MODE_SYNC);
   assign int_tb = bcmp_q[`SUS_BCMP_INT];
   assign cmp = bcmp_q[14:0];
   assign cts_edge = !cts_n_s && e_q.cts_prev; // Fresh assertion only
   assign bclk_rise = bclk_s && !e_q.bclk_prev; // Low sample then high sample
   assign wr_go = aw_have_q && w_have_q && !bvalid;
   assign rd_go = arvalid && arready;
   assign rd_sts = rd_go && (araddr == `SUS_OFF_STS);

   // Bus slave and register file next values
   always_comb begin
      aw_have_d = aw_have_q;
      awaddr_d = awaddr_q;
      w_have_d = w_have_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid;
      bresp_d = bresp;
      rvalid_d = rvalid;
      rresp_d = rresp;
      rdata_d = rdata;
      ctrl_d = ctrl_q;
      bcmp_d = bcmp_q;
      tbuf_d = tbuf_q;
      rbuf_d = rbuf_q;
      tbuf_full_d = tbuf_full_q;
      rx_req_d = rx_req_q;
      if (awvalid && awready) begin
         aw_have_d = 1'b1;
         awaddr_d = awaddr;
      end
      if (wvalid && wready) begin
         w_have_d = 1'b1;
         wdata_d = wdata;
         wstrb_d = wstrb;
      end
      if (bvalid && bready) begin
         bvalid_d = 1'b0;
      end
      if (tx_load) begin
         tbuf_full_d = 1'b0;
      end
      if (rx_start) begin
         rx_req_d = 1'b0;
      end
      // Write decode, low lane holds byte-wide registers
      if (wr_go) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = `SUS_RESP_OKAY;
         if (awaddr_q == `SUS_OFF_CTRL) begin
            if (wstrb_q[0]) begin
               ctrl_d = sus_ctrl_t'(wdata_q[5:0]); // Break bit stored only
               if (wdata_q[4] && !ri_q) begin
                  rx_req_d = 1'b1;
               end
            end
         end else if (awaddr_q == `SUS_OFF_TBUF) begin
            if (wstrb_q[0]) begin
               tbuf_d = wdata_q[7:0];
               tbuf_full_d = 1'b1;
            end
         end else if (awaddr_q == `SUS_OFF_BCMP) begin
            if (wstrb_q[0]) begin
               bcmp_d[7:0] = wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               bcmp_d[15:8] = wdata_q[15:8];
            end
         end else if (awaddr_q == `SUS_OFF_STS || awaddr_q == `SUS_OFF_RBUF ||
                      awaddr_q == `SUS_OFF_BCNT) begin
            bresp_d = `SUS_RESP_OKAY;
         end else begin
            bresp_d = `SUS_RESP_SLVERR;
         end
      end
      if (rvalid && rready) begin
         rvalid_d = 1'b0;
      end
      // Read decode; async error bits read zero, break bit reads back as stored
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = `SUS_RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (araddr == `SUS_OFF_CTRL) begin
            rdata_d[5:0] = ctrl_q;
         end else if (araddr == `SUS_OFF_STS) begin
            rdata_d[`SUS_STS_TXE] = !tbuf_full_q && !(e_q.is_tx && e_q.st != SH_IDLE);
            rdata_d[`SUS_STS_TI] = ti_q;
            rdata_d[`SUS_STS_RI] = ri_q;
            rdata_d[`SUS_STS_CTS] = !cts_n_s;
         end else if (araddr == `SUS_OFF_TBUF) begin
            rdata_d[7:0] = tbuf_q;
         end else if (araddr == `SUS_OFF_RBUF) begin
            rdata_d[7:0] = rbuf_q;
         end else if (araddr == `SUS_OFF_BCMP) begin
            rdata_d[15:0] = bcmp_q;
         end else if (araddr == `SUS_OFF_BCNT) begin
            rdata_d[14:0] = e_q.bcnt;
         end else begin
            rresp_d = `SUS_RESP_SLVERR;
         end
      end
      if (rx_done) begin
         rbuf_d = e_q.shreg;
      end
      // Status read clears flags, a new event wins
      ti_d = (ti_q && !rd_sts) || tx_done;
      ri_d = (ri_q && !rd_sts) || rx_done;
      tx_irq_d = ti_d;
      rx_irq_d = ri_d;
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   // Bus and register flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `SUS_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `SUS_RESP_OKAY;
         rdata <= 32'h0000_0000;
         ctrl_q <= sus_ctrl_t'(`SUS_CTRL_RST);
         bcmp_q <= `SUS_BCMP_RST;
         tbuf_q <= 8'h00;
         rbuf_q <= 8'h00;
         tbuf_full_q <= 1'b0;
         ti_q <= 1'b0;
         ri_q <= 1'b0;
         rx_req_q <= 1'b0;
         chan1_tx_irq_out <= 1'b0;
         chan1_rx_irq_out <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         awaddr_q <= awaddr_d;
         w_have_q <= w_have_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready <= awready_d;
         wready <= wready_d;
         arready <= arready_d;
         bvalid <= bvalid_d;
         bresp <= bresp_d;
         rvalid <= rvalid_d;
         rresp <= rresp_d;
         rdata <= rdata_d;
         ctrl_q <= ctrl_d;
         bcmp_q <= bcmp_d;
         tbuf_q <= tbuf_d;
         rbuf_q <= rbuf_d;
         tbuf_full_q <= tbuf_full_d;
         ti_q <= ti_d;
         ri_q <= ri_d;
         rx_req_q <= rx_req_d;
         chan1_tx_irq_out <= tx_irq_d;
         chan1_rx_irq_out <= rx_irq_d;
      end
   end

   // Shift engine: baud counter, shift clock phases and data shifting
   always_comb begin
      e_d = e_q;
      tx_load = 1'b0;
      rx_start = 1'b0;
      tx_done = 1'b0;
      rx_done = 1'b0;
      match = 1'b0;
      ext_match = 1'b0;
      tick = 1'b0;
      e_d.cts_prev = cts_n_s;
      e_d.bclk_prev = bclk_s;
      inc = int_tb ? 1'b1 : bclk_rise; // External clock only steps the count
      if (e_q.st != SH_IDLE) begin
         if (e_q.dly) begin
            if (e_q.dcnt == 3'h1) begin
               e_d.dly = 1'b0;
               tick = 1'b1; // Pin edge timed on CPU clock
            end else begin
               e_d.dcnt = e_q.dcnt - 3'h1;
            end
         end
         if (inc) begin
            if (e_q.bcnt == cmp) begin
               e_d.bcnt = 15'h0000; // Restart on match
               match = 1'b1;
            end else begin
               e_d.bcnt = e_q.bcnt + 15'h0001;
            end
         end
         if (match && int_tb) begin
            tick = 1'b1;
         end else if (match) begin
            ext_match = 1'b1;
            e_d.dly = 1'b1;
            e_d.dcnt = 3'(`SUS_EXT_DLY_CYC);
         end
      end
      case (e_q.st)
         SH_IDLE: begin
            e_d.bcnt = 15'h0000;
            e_d.dly = 1'b0;
            e_d.nbit = 4'h0;
            if (sync_mode && tbuf_full_q && (!ctrl_q.cts_en || cts_edge)) begin
               tx_load = 1'b1;
               e_d.st = SH_WAIT;
               e_d.is_tx = 1'b1;
               e_d.shreg = tbuf_q;
               e_d.dout = tbuf_q[0];
               e_d.doe_n = 1'b0; // Drive data only while sending
            end else if (sync_mode && rx_req_q) begin
               rx_start = 1'b1;
               e_d.st = SH_WAIT;
               e_d.is_tx = 1'b0;
            end
         end
         SH_WAIT: begin
            if (tick) begin
               e_d.st = SH_LOW;
               e_d.lcnt = 2'(`SUS_LOW_CYC - 1);
            end
         end
         SH_LOW: begin
            if (e_q.lcnt == 2'h0) begin
               e_d.st = SH_HIGH; // Two low cycles then rise
               e_d.rise = 1'b1;
               e_d.nbit = e_q.nbit + 4'h1;
               if (!e_q.is_tx) begin
                  e_d.shreg = {rxd_s, e_q.shreg[7:1]}; // Sample at shift clock rise
               end
            end else begin
               e_d.lcnt = e_q.lcnt - 2'h1;
            end
         end
         SH_HIGH: begin
            e_d.rise = 1'b0;
            if (e_q.rise && e_q.nbit == `SUS_NBITS) begin
               e_d.st = SH_IDLE;
               e_d.doe_n = 1'b1; // Release data pin
               tx_done = e_q.is_tx;
               rx_done = !e_q.is_tx;
            end else begin
               if (e_q.rise && e_q.is_tx) begin
                  e_d.shreg = {1'b0, e_q.shreg[7:1]};
                  e_d.dout = e_q.shreg[1]; // One clock after rise
               end
               if (tick) begin
                  e_d.st = SH_LOW;
                  e_d.lcnt = 2'(`SUS_LOW_CYC - 1);
               end
            end
         end
         default: begin
            e_d.st = SH_IDLE;
         end
      endcase
      if (!sync_mode) begin
         e_d.st = SH_IDLE;
         e_d.doe_n = 1'b1;
      end
      e_d.txd = (e_d.st != SH_LOW); // Always driven, idle high
   end

   // Shift engine flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         e_q <= '{st: SH_IDLE, is_tx: 1'b0, nbit: 4'h0, shreg: 8'h00, lcnt: 2'h0, dcnt: 3'h0,
                  dly: 1'b0, rise: 1'b0, bcnt: 15'h0000, cts_prev: 1'b1, bclk_prev: 1'b0,
                  txd: 1'b1, dout: 1'b1, doe_n: 1'b1};
      end else begin
         e_q <= e_d;
      end
   end

   assign txd = e_q.txd;
   assign rxd_out = e_q.dout;
   assign rxd_oe_n = e_q.doe_n;

   // Checks on the shift timing and flags
   logic [15:0] hi_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_cnt_q <= 16'h0000;
      end else begin
         hi_cnt_q <= txd ? hi_cnt_q + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence low_pulse_s;
      !txd ##1 !txd ##1 txd;
   endsequence

   idle_high_a: assert property (e_q.st == SH_IDLE |-> txd)
      else $error("shift clock not high while idle");
   data_float_a: assert property ((e_q.st == SH_IDLE || !e_q.is_tx) |-> rxd_oe_n)
      else $error("data pin driven outside transmission");
   low_two_a: assert property ($fell(txd) |-> low_pulse_s)
      else $error("shift clock low phase not two cycles");
   high_len_a: assert property ($fell(txd) && int_tb && $past(e_q.st) == SH_HIGH
         |-> hi_cnt_q == 16'(cmp) - 16'h0001)
      else $error("shift clock high phase length wrong");
   data_change_a: assert property ($changed(rxd_out) && !rxd_oe_n && !$past(rxd_oe_n)
         |-> $past(txd) && !$past(txd, 2))
      else $error("data changed away from shift clock rise");
   sts_clear_a: assert property (rd_sts && !tx_done |=> !ti_q)
      else $error("status read did not clear transmit done");
   ti_irq_a: assert property (tx_done |=> ti_q && chan1_tx_irq_out)
      else $error("transmit done or interrupt missing");
   rx_gate_a: assert property ($rose(rx_req_q) |-> !$past(ri_q))
      else $error("reception armed while receive done set");
   cts_gate_a: assert property (tx_load && ctrl_q.cts_en |-> cts_edge)
      else $error("gated send started without fresh clear to send");
   ext_fall_a: assert property (ext_match && e_q.st != SH_LOW && !e_q.dly
         |-> ##5 !txd)
      else $error("external timebase fall not at fixed delay");
   bclk_inc_a: assert property (!int_tb && bclk_rise && e_q.st != SH_IDLE
         && e_q.bcnt != cmp |=> e_q.bcnt == $past(e_q.bcnt) + 15'h0001)
      else $error("baud counter not stepped by clock edge");
endmodule : sus_top

// file: hdl/sus_consts.svh
// Constants of the synchronous serial unit: offsets, fields, resets, timing
// Contract
// - Transmit buffer write starts sending; done and empty flags track buffer and shifter.
// - Send-break bit has no effect on sync transmit or receive.
// - Setting receive_enable starts reception at once, only while receive-done is clear.
// - Overrun, framing, parity and break flags are meaningless in sync mode.
// - Gated send waits for clear-to-send asserted while pending; earlier assertion ignored.
// - Clear-to-send is synchronised to the CPU clock before use.
// - Synchronised baud clock low-then-high sample advances the baud counter once.
// - Baud clock input passes a synchroniser before reaching the timebase.
// - Shift clock pin always driven, idle high; data pin floats unless transmitting.
// - Internal timebase: shift clock low two periods, high compare minus one.
// - Transmit data changes one clock after each shift clock rising edge.
// - External timebase only advances counter; pin edges stay on CPU clock.
// - External timebase: shift clock falls 5 clocks after match, low two.
// - Receive-done and transmit-done request an interrupt per character.
// - Channel interrupt outputs go active at the end of each character.
// - Reading the status register clears pending receive-done and transmit-done.
`ifndef SUS_CONSTS_SVH
`define SUS_CONSTS_SVH
`define SUS_OFF_CTRL 8'h00
`define SUS_OFF_STS 8'h04
`define SUS_OFF_TBUF 8'h08
`define SUS_OFF_RBUF 8'h0C
`define SUS_OFF_BCMP 8'h10
`define SUS_OFF_BCNT 8'h14
`define SUS_CTRL_RST 6'h00
`define SUS_BCMP_RST 16'h8002
`define SUS_MODE_SYNC 3'h0
`define SUS_BCMP_INT 15
`define SUS_STS_TXE 0
`define SUS_STS_TI 1
`define SUS_STS_RI 2
`define SUS_STS_CTS 3
`define SUS_LOW_CYC 2
`define SUS_EXT_DLY_HALF 9
`define SUS_EXT_DLY_CYC (`SUS_EXT_DLY_HALF / 2)
`define SUS_NBITS 4'h8
`define SUS_RESP_OKAY 2'h0
`define SUS_RESP_SLVERR 2'h2
`endif

// file: hdl/sus_pkg.sv
// Types of the synchronous serial unit
package sus_pkg;
   typedef struct packed {
      logic send_break;
      logic rx_en;
      logic cts_en;
      logic [2:0] mode;
   } sus_ctrl_t;
   typedef enum logic [1:0] {
      SH_IDLE = 2'h0,
      SH_WAIT = 2'h1,
      SH_LOW = 2'h3,
      SH_HIGH = 2'h2
   } sus_sh_t;
   typedef struct packed {
      sus_sh_t st;
      logic is_tx;
      logic [3:0] nbit;
      logic [7:0] shreg;
      logic [1:0] lcnt;
      logic [2:0] dcnt;
      logic dly;
      logic rise;
      logic [14:0] bcnt;
      logic cts_prev;
      logic bclk_prev;
      logic txd;
      logic dout;
      logic doe_n;
   } sus_eng_t;
endpackage : sus_pkg

// file: hdl/sus_sync.sv
// Two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module sus_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic d,
   output logic q
);
   logic meta_q;
   // First stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sus_sync

// file: bench/sus_peer.sv
// Behavioural external shift register on the synchronous data pin
`timescale 1ns/1ps
module sus_peer (
   input wire logic aclk,
   input wire logic clr,
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe_n,
   input wire logic drive_en,
   input wire logic [7:0] tx_byte,
   output logic rxd_in,
   output logic [7:0] got_byte,
   output logic [3:0] nbits
);
   logic [7:0] shout_q;
   logic last_q = 1'b0;
   // Pin level: device, peer, or a released line showing the inverse of its last level
   assign rxd_in = !rxd_oe_n ? rxd_out : (drive_en ? shout_q[0] : ~last_q);
   // Remember the last driven level of the pin
   always @(posedge aclk) begin
      if (!rxd_oe_n || drive_en) begin
         last_q <= rxd_in;
      end
   end
   // Capture and present bits at each rising shift clock edge, LSB first
   always @(posedge txd or posedge clr) begin
      if (clr) begin
         nbits <= 4'h0;
         shout_q <= tx_byte;
      end else begin
         got_byte <= {rxd_in, got_byte[7:1]};
         nbits <= nbits + 4'h1;
         shout_q <= {1'b0, shout_q[7:1]};
      end
   end
endmodule : sus_peer

// file: bench/sus_top_tb.sv
// Self-checking bench of the synchronous serial unit
`timescale 1ns/1ps
`include "sus_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %0h exp %0h", $time, (g), (e)); end end
module sus_top_tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic cts_n = 1, baud_clock_in = 0, bclk_run = 0, drive_en = 0, clr = 0;
   logic [7:0] awaddr = 0, araddr = 0, tx_byte = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid, txd, rxd_in, rxd_out, rxd_oe_n;
   logic irq_rx, irq_tx;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] got_byte;
   logic [3:0] nbits;
   int n_errors = 0, total_checks = 0, lo_n = 0, hi_n = 0, exp_hi = 0;
   // Clock and link clock; the link clock toggles only while bclk_run is set
   always #4 aclk = ~aclk;
   always begin
      #62.5;
      if (bclk_run) baud_clock_in <= ~baud_clock_in;
   end
   sus_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .cts_n(cts_n), .baud_clock_in(baud_clock_in),
      .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
      .chan1_rx_irq_out(irq_rx), .chan1_tx_irq_out(irq_tx));
   sus_peer u_peer (.aclk(aclk), .clr(clr), .txd(txd), .rxd_out(rxd_out),
      .rxd_oe_n(rxd_oe_n), .drive_en(drive_en), .tx_byte(tx_byte), .rxd_in(rxd_in),
      .got_byte(got_byte), .nbits(nbits));
   // Measure shift clock low and high phase lengths inside frames
   always @(posedge aclk) begin
      if (aresetn && !txd) begin
         if (hi_n > 0 && exp_hi > 0 && nbits > 0 && nbits < 8) `CHK(hi_n, exp_hi)
         hi_n = 0;
         lo_n++;
      end else if (aresetn) begin
         if (lo_n > 0) `CHK(lo_n, 2)
         lo_n = 0;
         hi_n++;
      end
   end
   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   task automatic fail;
      n_errors++;
      end_sim;
   endtask : fail
   // Register write over the bus, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      bit ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 200 && !(ad && wd); i++) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
         if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
      end
      if (!(ad && wd)) fail;
      bready <= 1'b1;
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (bvalid === 1'b1) break;
      end
      if (i == 200) fail;
      `CHK(bresp, (a > `SUS_OFF_BCNT) ? `SUS_RESP_SLVERR : `SUS_RESP_OKAY)
      bready <= 1'b0;
   endtask : wr
   // Register read over the bus, compared with the expected word and response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (arready === 1'b1) break;
      end
      if (i == 200) fail;
      arvalid <= 1'b0;
      rready <= 1'b1;
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (rvalid === 1'b1) break;
      end
      if (i == 200) fail;
      `CHK(rdata, ed)
      `CHK(rresp, er)
      rready <= 1'b0;
   endtask : rd_chk
   // Wait for the receive or transmit interrupt output
   task automatic wait_irq(input bit rx);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge aclk);
         if ((rx ? irq_rx : irq_tx) === 1'b1) break;
      end
      if (i == 3000) fail;
   endtask : wait_irq
   // Restart the peer's bit count and load its outgoing byte
   task automatic clr_peer;
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
   endtask : clr_peer
   // Reset values, idle pins and an unmapped address
   task automatic t_reset;
      `CHK(txd, 1'b1)
      `CHK(rxd_oe_n, 1'b1)
      rd_chk(`SUS_OFF_CTRL, 32'h0, `SUS_RESP_OKAY);
      rd_chk(`SUS_OFF_BCMP, 32'h8002, `SUS_RESP_OKAY);
      rd_chk(`SUS_OFF_STS, 32'h1, `SUS_RESP_OKAY);
      rd_chk(8'h18, 32'h0, `SUS_RESP_SLVERR);
   endtask : t_reset
   // One transmitted character, its flags, interrupt and status clear
   task automatic t_tx(input logic [31:0] bc, input logic [31:0] ct, input logic [7:0] b,
                       input int eh);
      exp_hi = eh;
      wr(`SUS_OFF_BCMP, bc);
      wr(`SUS_OFF_CTRL, ct);
      clr_peer;
      wr(`SUS_OFF_TBUF, {24'h0, b});
      wait_irq(1'b0);
      `CHK(got_byte, b)
      `CHK(nbits, 4'h8)
      `CHK(rxd_oe_n, 1'b1)
      rd_chk(`SUS_OFF_STS, 32'h3, `SUS_RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(irq_tx, 1'b0)
      `CHK(txd, 1'b1)
      rd_chk(`SUS_OFF_STS, 32'h1, `SUS_RESP_OKAY);
   endtask : t_tx
   // Reception, then a refused second request while receive-done is set
   task automatic t_rx;
      exp_hi = 2;
      wr(`SUS_OFF_BCMP, 32'h8003);
      tx_byte <= 8'h3C;
      drive_en <= 1'b1;
      clr_peer;
      wr(`SUS_OFF_CTRL, 32'h10);
      wait_irq(1'b1);
      clr_peer;
      wr(`SUS_OFF_CTRL, 32'h10);
      repeat (40) @(posedge aclk);
      `CHK(nbits, 4'h0)
      `CHK(irq_rx, 1'b1)
      rd_chk(`SUS_OFF_RBUF, 32'h3C, `SUS_RESP_OKAY);
      rd_chk(`SUS_OFF_STS, 32'h5, `SUS_RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(irq_rx, 1'b0)
      drive_en <= 1'b0;
      wr(`SUS_OFF_CTRL, 32'h0);
   endtask : t_rx
   // Clear-to-send gating: early assertion ignored, fresh assertion starts
   task automatic t_cts;
      wr(`SUS_OFF_CTRL, 32'h08);
      cts_n <= 1'b0;
      repeat (4) @(posedge aclk);
      clr_peer;
      wr(`SUS_OFF_TBUF, 32'hC3);
      repeat (60) @(posedge aclk);
      `CHK(nbits, 4'h0)
      rd_chk(`SUS_OFF_STS, 32'h8, `SUS_RESP_OKAY);
      cts_n <= 1'b1;
      repeat (4) @(posedge aclk);
      cts_n <= 1'b0;
      wait_irq(1'b0);
      `CHK(got_byte, 8'hC3)
      rd_chk(`SUS_OFF_STS, 32'hB, `SUS_RESP_OKAY);
      cts_n <= 1'b1;
   endtask : t_cts
   // Unmapped write, idle counter, and a non-sync mode that holds a loaded character
   task automatic t_mode;
      wr(8'h18, 32'h0);
      rd_chk(`SUS_OFF_BCNT, 32'h0, `SUS_RESP_OKAY);
      wr(`SUS_OFF_CTRL, 32'h01);
      clr_peer;
      wr(`SUS_OFF_TBUF, 32'h66);
      repeat (60) @(posedge aclk);
      `CHK(nbits, 4'h0)
      `CHK(txd, 1'b1)
      rd_chk(`SUS_OFF_STS, 32'h0, `SUS_RESP_OKAY);
      wr(`SUS_OFF_CTRL, 32'h0);
      wait_irq(1'b0);
      `CHK(got_byte, 8'h66)
      rd_chk(`SUS_OFF_STS, 32'h3, `SUS_RESP_OKAY);
   endtask : t_mode
   // Main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset;
      t_tx(32'h8003, 32'h20, 8'hA5, 2);
      bclk_run <= 1'b1;
      t_tx(32'h0002, 32'h0, 8'h5A, 0);
      bclk_run <= 1'b0;
      t_rx;
      t_cts;
      t_mode;
      end_sim;
   end
endmodule : sus_top_tb
